/* File: verilog/sram_pkg.sv */
// Purpose: shared constants and carriers for the single-bit static memory host controller
// Assumes: 200 MHz clock, fastest speed grade of the memory
// Notes:   times in picoseconds, counts derived from the clock period
package sram_pkg;
	localparam int ADDR_W       = 16;
	localparam int DEPTH        = 65536;
	localparam int CLK_PERIOD_PS = 5000;
	// Memory timing, fastest grade
	localparam int ADDR_ACCESS_TIME_PS       = 15000;
	localparam int SELECT_ACCESS_TIME_PS     = 15000;
	localparam int OUT_HOLD_AFTER_ADDR_PS    = 3000;
	localparam int DESELECT_TO_POWERDOWN_PS  = 15000;
	localparam int ADDR_SETUP_TO_WRITE_END_PS = 12000;
	localparam int WRITE_PULSE_PS            = 12000;
	localparam int DATA_SETUP_PS             = 10000;
	localparam int CYCLE_TIME_PS             = 15000;
	// Least times round up
	localparam int ACCESS_CYC = (((ADDR_ACCESS_TIME_PS > SELECT_ACCESS_TIME_PS) ?
		ADDR_ACCESS_TIME_PS : SELECT_ACCESS_TIME_PS) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WRITE_CYC_RAW = (ADDR_SETUP_TO_WRITE_END_PS + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int WRITE_CYC = (WRITE_CYC_RAW < 1) ? 1 : WRITE_CYC_RAW;
	localparam int PD_CYC = (DESELECT_TO_POWERDOWN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] ACCESS_CNT = CNT_W'(ACCESS_CYC);
	localparam logic [CNT_W-1:0] WRITE_CNT  = CNT_W'(WRITE_CYC);
	localparam logic [CNT_W-1:0] PD_CNT     = CNT_W'(PD_CYC);

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_SETUP = 3'h1,
		ST_WRITE = 3'h2,
		ST_READ  = 3'h3,
		ST_END   = 3'h4
	} sram_state_t;

	// Pins driven toward the memory
	typedef struct packed {
		logic              sel_n;
		logic              wr_n;
		logic [ADDR_W-1:0] addr_lines;
		logic              din;
	} sram_pins_t;

	// User request
	typedef struct packed {
		logic              valid;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic              wdata;
	} sram_req_t;
endpackage

/* File: verilog/sram_delay_cnt.sv */
// Purpose: loadable down-counter giving a one-cycle done pulse
// Assumes: load and count in the same clock domain
// Notes:   done pulses the cycle after the count reaches one, so a load of n
//          gives done n cycles after the loading edge
module sram_delay_cnt #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              done
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         done;
	} sram_cnt_state_t;

	sram_cnt_state_t s_q;
	sram_cnt_state_t s_d;

	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		if (load) begin
			s_d.cnt = value;
		end else if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - W'(1);
			if (s_q.cnt == W'(1)) begin
				s_d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done = s_q.done;
endmodule // sram_delay_cnt

/* File: verilog/sram_host.sv */
// Purpose: host controller driving a 64K x 1 asynchronous static memory
// Assumes: memory data output sampled synchronously; one access at a time
// Notes:   select controlled write, write strobe falls with select and both rise together
module sram_host #(
	parameter int ADDR_W = sram_pkg::ADDR_W
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire sram_pkg::sram_req_t req,
	output logic                     req_ready,
	output logic                     rd_valid,
	output logic                     rd_data,
	output logic                     powered_down,
	output sram_pkg::sram_pins_t     pins,
	input  wire logic                mem_dout
);
	typedef struct packed {
		sram_pkg::sram_state_t st;
		sram_pkg::sram_pins_t  pins;
		logic                  wr_pend;
		logic                  ready;
		logic                  rd_valid;
		logic                  rd_data;
		logic                  pd;
		logic                  pd_wait;
	} sram_host_state_t;

	sram_host_state_t s_q;
	sram_host_state_t s_d;
	logic             cnt_load;
	logic [sram_pkg::CNT_W-1:0] cnt_val;
	logic             cnt_done;

	if (ADDR_W != sram_pkg::ADDR_W) begin : g_chk
		$error("sram_host: address width must be sixteen");
	end

	if ((1 << ADDR_W) != sram_pkg::DEPTH) begin : g_chk_depth
		$error("sram_host: depth must match the address width");
	end

	// Every count must fit the shared down-counter
	if (sram_pkg::ACCESS_CYC > (1 << sram_pkg::CNT_W) - 1) begin : g_chk_access_w
		$error("sram_host: access count too wide for the counter");
	end

	if (sram_pkg::WRITE_CYC > (1 << sram_pkg::CNT_W) - 1) begin : g_chk_write_w
		$error("sram_host: write count too wide for the counter");
	end

	if (sram_pkg::PD_CYC > (1 << sram_pkg::CNT_W) - 1) begin : g_chk_pd_w
		$error("sram_host: power-down count too wide for the counter");
	end

	// Counted cycles must cover the memory's least times
	if (sram_pkg::WRITE_CYC * sram_pkg::CLK_PERIOD_PS < sram_pkg::WRITE_PULSE_PS) begin : g_chk_pulse
		$error("sram_host: write pulse shorter than the memory needs");
	end

	if ((sram_pkg::ACCESS_CYC + 1) * sram_pkg::CLK_PERIOD_PS < sram_pkg::CYCLE_TIME_PS) begin : g_chk_cyc
		$error("sram_host: select window shorter than a memory cycle");
	end

	if ((sram_pkg::WRITE_CYC + 2) * sram_pkg::CLK_PERIOD_PS < sram_pkg::DATA_SETUP_PS) begin : g_chk_ds
		$error("sram_host: data setup to write end too short");
	end

	sram_delay_cnt #(
		.W (sram_pkg::CNT_W)
	) u_cnt (
		.clk     (clk),
		.sys_rst (sys_rst),
		.load    (cnt_load),
		.value   (cnt_val),
		.done    (cnt_done)
	);

	always_comb begin
		s_d         = s_q;
		cnt_load    = 1'b0;
		cnt_val     = sram_pkg::ACCESS_CNT;
		s_d.rd_valid = 1'b0;
		// Deselected power-down tracking
		if (s_q.pd_wait && cnt_done) begin
			s_d.pd      = 1'b1;
			s_d.pd_wait = 1'b0;
		end
		unique case (s_q.st)
			sram_pkg::ST_IDLE: begin
				if (req.valid && s_q.ready) begin
					// Address and data go out one cycle before select falls
					s_d.pins.addr_lines = req.addr;
					s_d.pins.din        = req.wdata;
					s_d.wr_pend         = req.write;
					s_d.ready           = 1'b0;
					s_d.st              = sram_pkg::ST_SETUP;
				end
			end
			sram_pkg::ST_SETUP: begin
				s_d.pins.sel_n = 1'b0;
				s_d.pd         = 1'b0;
				s_d.pd_wait    = 1'b0;
				cnt_load       = 1'b1;
				if (s_q.wr_pend) begin
					s_d.pins.wr_n = 1'b0;
					cnt_val       = sram_pkg::WRITE_CNT;
					s_d.st        = sram_pkg::ST_WRITE;
				end else begin
					s_d.pins.wr_n = 1'b1;
					cnt_val       = sram_pkg::ACCESS_CNT;
					s_d.st        = sram_pkg::ST_READ;
				end
			end
			sram_pkg::ST_WRITE: begin
				if (cnt_done) begin
					// Both rise together; address and data still held
					s_d.pins.sel_n = 1'b1;
					s_d.pins.wr_n  = 1'b1;
					s_d.st         = sram_pkg::ST_END;
				end
			end
			sram_pkg::ST_READ: begin
				if (cnt_done) begin
					s_d.rd_data    = mem_dout;
					s_d.rd_valid   = 1'b1;
					s_d.pins.sel_n = 1'b1;
					s_d.st         = sram_pkg::ST_END;
				end
			end
			sram_pkg::ST_END: begin
				// Address held one more cycle after deselect
				cnt_load    = 1'b1;
				cnt_val     = sram_pkg::PD_CNT;
				s_d.pd_wait = 1'b1;
				s_d.ready   = 1'b1;
				s_d.st      = sram_pkg::ST_IDLE;
			end
			default: begin
				s_d.st = sram_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q               <= '0;
			s_q.st            <= sram_pkg::ST_IDLE;
			s_q.pins.sel_n    <= 1'b1;
			s_q.pins.wr_n     <= 1'b1;
			s_q.ready         <= 1'b1;
			s_q.pd            <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign req_ready    = s_q.ready;
	assign rd_valid     = s_q.rd_valid;
	assign rd_data      = s_q.rd_data;
	assign powered_down = s_q.pd;
	assign pins         = s_q.pins;
endmodule // sram_host

/* File: bench/sram_host_chk.sv */
// Purpose: pin timing checks for the static memory host
// Assumes: one clock of 5 ns, synchronous reset
// Notes:   sees only the host ports
module sram_host_chk (
	input wire logic                 clk,
	input wire logic                 sys_rst,
	input wire sram_pkg::sram_req_t  req,
	input wire logic                 req_ready,
	input wire logic                 rd_valid,
	input wire logic                 rd_data,
	input wire logic                 powered_down,
	input wire sram_pkg::sram_pins_t pins,
	input wire logic                 mem_dout
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_addr_held_sel: assert property (!pins.sel_n |-> $stable(pins.addr_lines))
		else $error("address moved while selected");
	a_din_held_wr: assert property (!pins.wr_n |-> $stable(pins.din))
		else $error("write data moved during write");
	a_write_width: assert property ($fell(pins.wr_n) |-> !pins.wr_n [*4] ##1 pins.wr_n)
		else $error("write pulse not four cycles");
	a_write_end_both: assert property ($rose(pins.wr_n) |-> $rose(pins.sel_n))
		else $error("write strobes did not end together");
	a_read_sample: assert property (($fell(pins.sel_n) && pins.wr_n) |->
		##4 (rd_valid && rd_data == $past(mem_dout)))
		else $error("read data not taken at 20 ns");
	a_pd_clear: assert property (!pins.sel_n |-> !powered_down)
		else $error("power-down shown while selected");
	a_pd_set: assert property ($rose(pins.sel_n) ##1 pins.sel_n [*4] |=> powered_down)
		else $error("power-down not shown after deselect");
	a_pd_not_early: assert property ($rose(pins.sel_n) |-> !powered_down [*3])
		else $error("power-down shown before 15 ns");
	cover property ($rose(pins.wr_n));
	cover property (rd_valid);
	cover property ($rose(powered_down));
endmodule // sram_host_chk

bind sram_host sram_host_chk u_sram_host_chk (.clk, .sys_rst, .req, .req_ready, .rd_valid,
	.rd_data, .powered_down, .pins, .mem_dout);

/* File: bench/sram_mem_model.sv */
// Purpose: behavioural 64K x 1 static memory
// Assumes: output valid 14 ns after its last cause
// Notes:   a floating output shows a toggling pattern
module sram_mem_model (
	input wire logic        sel_n,
	input wire logic        wr_n,
	input wire logic [15:0] addr_lines,
	input wire logic        din,
	output logic            dout
);
	timeunit 1ns;
	timeprecision 100ps;
	logic bits [0:65535];
	logic junk = 1'b0;
	logic        ok = 1'b0;
	logic        stale = 1'b0;
	logic        old = 1'b0;
	logic [15:0] last_addr = '0;
	int          gen = 0;
	always #1 junk = ~junk;
	always @* if (!sel_n && !wr_n) bits[addr_lines] = din;
	always @(sel_n, wr_n, addr_lines) begin
		gen++;
		// Previous word lingers briefly after the address moves during a read
		stale = ok && !sel_n && wr_n;
		old = bits[last_addr];
		last_addr = addr_lines;
		ok = 1'b0;
		fork
			automatic int g = gen;
			begin
				#3 if (g == gen) stale = 1'b0;
				#11 if (g == gen) ok = 1'b1;
			end
		join_none
	end
	assign dout = (ok && !sel_n && wr_n) ? bits[addr_lines] :
		((stale && !sel_n && wr_n) ? old : junk);
endmodule // sram_mem_model

/* File: bench/sram_host_tb.sv */
// Purpose: self-checking bench for the static memory host
// Assumes: memory model answers within 15 ns
// Notes:   inputs change on the falling clock edge
module sram_host_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic                 clk, sys_rst, req_ready, rd_valid, rd_data, powered_down, mem_dout, q;
	sram_pkg::sram_req_t  req;
	sram_pkg::sram_pins_t pins;
	int                   bad_count = 0, compares = 0;
	sram_host u_sram_host (.clk, .sys_rst, .req, .req_ready, .rd_valid, .rd_data,
		.powered_down, .pins, .mem_dout);
	sram_mem_model u_sram_mem_model (.sel_n(pins.sel_n), .wr_n(pins.wr_n),
		.addr_lines(pins.addr_lines), .din(pins.din), .dout(mem_dout));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict;
		$display("bad_count %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic access(logic w, logic [15:0] a, logic d);
		int n;
		req = '{1'b1, w, a, d};
		for (n = 0; req_ready !== 1'b1; n++) begin
			if (n > 20) begin
				bad_count++;
				give_verdict();
			end
			@(negedge clk);
		end
		@(negedge clk);
		req.valid = 1'b0;
		for (n = 0; !w && rd_valid !== 1'b1; n++) begin
			if (n > 20) begin
				bad_count++;
				give_verdict();
			end
			@(negedge clk);
		end
		q = rd_data;
	endtask
	task automatic t_fill;
		logic [15:0] ad [5] = '{16'h0000, 16'hffff, 16'h0001, 16'h8000, 16'h5a5a};
		foreach (ad[i]) access(1'b1, ad[i], i[0]);
		foreach (ad[i]) begin
			access(1'b0, ad[i], 1'b0);
			check("rd_data", 16'(i[0]), 16'(q));
		end
	endtask
	task automatic t_overwrite;
		access(1'b1, 16'h1235, 1'b1);
		access(1'b1, 16'h1234, 1'b1);
		access(1'b1, 16'h1234, 1'b0);
		access(1'b0, 16'h1234, 1'b0);
		check("rd_new", 16'h0, 16'(q));
		access(1'b0, 16'h1234, 1'b0);
		check("rd_again", 16'h0, 16'(q));
		access(1'b0, 16'h1235, 1'b0);
		check("rd_neighbour", 16'h1, 16'(q));
	endtask
	task automatic t_powerdown;
		int n;
		access(1'b0, 16'h0000, 1'b0);
		check("pd_early", 16'h0, 16'(powered_down));
		for (n = 0; powered_down !== 1'b1 && n < 6; n++) @(negedge clk);
		check("pd_late", 16'h1, 16'(powered_down));
	endtask
	initial begin
		sys_rst = 1'b1;
		req = '0;
		repeat (4) @(negedge clk);
		check("sel_idle", 16'h1, 16'(pins.sel_n));
		check("pd_reset", 16'h1, 16'(powered_down));
		sys_rst = 1'b0;
		t_fill();
		t_overwrite();
		t_powerdown();
		give_verdict();
	end
endmodule // sram_host_tb
